// File: accum_adder.sv
module accum_adder
   import dsp_load_pkg::*;
(
   core_link_if.adder lk
);
   logic [31:0] shifted;
   logic [32:0] raw;

   always_comb begin
      case (lk.pm)
         PM_NONE:  shifted = lk.product_register;
         PM_LEFT1: shifted = {lk.product_register[30:0], 1'b0};
         PM_LEFT4: shifted = {lk.product_register[27:0], 4'h0};
         default:  shifted = {{6{lk.product_register[31]}}, lk.product_register[31:6]};
      endcase
   end

   assign raw      = {1'b0, lk.acc} + {1'b0, shifted}; // RULE11
   assign lk.carry = raw[32]; // RULE12
   // signed overflow: like signs in, other sign out
   assign lk.ovf = (lk.acc[31] == shifted[31]) && (raw[31] != lk.acc[31]); // RULE21
   assign lk.sum = (lk.ovf && lk.overflow_mode_bit) ? (lk.acc[31] ? ACC_MAX_NEG : ACC_MAX_POS)
                                      : raw[31:0]; // RULE21
endmodule

// File: addr_gen.sv
module addr_gen
   import dsp_load_pkg::*;
(
   input wire logic   clk,
   input wire logic   rst_n,
   core_link_if.addr  lk
);
   logic [15:0] src;

   // source pointer of a mapped load walks upward per repetition
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src <= 16'h0000;
      end else if (lk.load) begin
         src <= lk.src_start;
      end else if (lk.step) begin
         src <= src + 16'h0001; // RULE20
      end
   end

   assign lk.rd_addr  = lk.map_src  ? src :
                        lk.indirect ? lk.ind_addr : {lk.dp, lk.offset}; // RULE18
   assign lk.dst_addr = {PAGE_ZERO, lk.offset}; // RULE19
endmodule

// File: core_link_if.sv
interface core_link_if;
   import dsp_load_pkg::*;
   logic [31:0] product_register;
   logic [31:0] acc;
   logic [1:0]  pm;
   logic        overflow_mode_bit;
   logic [31:0] sum;
   logic        carry;
   logic        ovf;
   logic [8:0]  dp;
   logic [6:0]  offset;
   logic        indirect;
   logic        map_src;
   logic [15:0] ind_addr;
   logic [15:0] src_start;
   logic        load;
   logic        step;
   logic [15:0] rd_addr;
   logic [15:0] dst_addr;

   modport adder (input product_register, acc, pm, overflow_mode_bit, output sum, carry, ovf);
   modport addr  (input dp, offset, indirect, map_src, ind_addr, src_start, load, step,
                  output rd_addr, dst_addr);
   modport core  (output product_register, acc, pm, overflow_mode_bit, dp, offset, indirect, map_src, ind_addr,
                  src_start, load, step,
                  input sum, carry, ovf, rd_addr, dst_addr);
endinterface

// File: dsp_load_pkg.sv
package dsp_load_pkg;

   // ------------------------------------------------------------
   // opcode decode
   // ------------------------------------------------------------
   localparam logic [7:0] OP_PRODUCT_HIGH = 8'h75;
   localparam logic [7:0] OP_OPERAND      = 8'h73;
   localparam logic [7:0] OP_OPERAND_ACC  = 8'h70;
   localparam logic [7:0] OP_MAPPED_LOAD  = 8'h89;
   localparam logic [6:0] OP_STATUS       = 7'h07;
   localparam int         STATUS_SEL_BIT  = 8;
   localparam int         INDIRECT_BIT    = 7;

   // ------------------------------------------------------------
   // status register fields
   // ------------------------------------------------------------
   localparam int ARP_HI  = 15;
   localparam int ARP_LO  = 13;
   localparam int OV_BIT  = 12;
   localparam int OVM_BIT = 11;
   localparam int GLOBAL_INTERRUPT_MASK_BIT = 9;
   localparam int ARB_HI  = 15;
   localparam int ARB_LO  = 13;
   localparam int C_BIT   = 9;
   localparam int PM_HI   = 1;
   localparam int PM_LO   = 0;
   localparam logic [15:0] ST0_RESET = 16'h0600;
   localparam logic [15:0] ST1_RESET = 16'h05f0;

   // ------------------------------------------------------------
   // product shift modes and saturation limits
   // ------------------------------------------------------------
   localparam logic [1:0]  PM_NONE   = 2'h0;
   localparam logic [1:0]  PM_LEFT1  = 2'h1;
   localparam logic [1:0]  PM_LEFT4  = 2'h2;
   localparam logic [31:0] ACC_MAX_POS = 32'h7fffffff;
   localparam logic [31:0] ACC_MAX_NEG = 32'h80000000;

   // ------------------------------------------------------------
   // mapped register page
   // ------------------------------------------------------------
   localparam int          MULT_OPERAND_REG_ONE_W      = 5;
   localparam int          MULT_OPERAND_REG_TWO_W      = 4;
   localparam logic [6:0]  MAP_MULT_OPERAND_REG_ZERO    = 7'h24;
   localparam logic [6:0]  MAP_MULT_OPERAND_REG_ONE    = 7'h25;
   localparam logic [6:0]  MAP_MULT_OPERAND_REG_TWO    = 7'h26;
   localparam logic [6:0]  PERIPH_BASE  = 7'h20;
   localparam logic [8:0]  PAGE_ZERO    = 9'h000;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_STALL = 3'b001,
      S_READ  = 3'b011,
      S_WRITE = 3'b010,
      S_PORT  = 3'b110
   } exec_state_t;

   typedef enum logic [2:0] {
      K_NONE, K_PH, K_ST0, K_ST1, K_TL, K_TLA, K_MAP
   } instr_kind_t;

endpackage

// File: dsp_register_load_exec.sv
// What this block does
// RULE1: product-high load writes memory word to product bits 31..16, low half kept
// RULE2: status load zero copies word into status zero except global interrupt mask
// RULE3: status load zero leaves aux pointer buffer untouched
// RULE4: indirect next-pointer ignored; aux pointer comes from word bits 13..15
// RULE5: status load one loads status one and copies new buffer into aux pointer
// RULE6: status load decoded when bits 15..9 are 0000111; bit 8 picks register
// RULE7: operand load writes operand zero, and ones and two when mode bit clear
// RULE8: mode bit clear makes every operand-zero load write all three operands
// RULE9: operand one keeps 5 low bits, operand two keeps 4 low bits
// RULE10: the three operand registers are readable and writable as mapped registers
// RULE11: load-accumulate loads operand zero and adds shifted product to accumulator
// RULE12: load-accumulate carry follows carry out; result depends on mode settings
// RULE13: these loads take one cycle, one more when sharing a single-access block
// RULE14: repeated mapped load takes 2n cycles, plus n for peripheral destination
// RULE15: single mapped load to a peripheral register costs one more cycle
// RULE16: repeated mapped load to a port takes 3n cycles plus port waits
// RULE17: repeated mapped load from external memory takes 2n plus read waits
// RULE18: direct address is page pointer joined with the 7-bit offset
// RULE19: mapped load destination forced onto page zero
// RULE20: repeated mapped load increments the source address after each load
// RULE21: load-accumulate flags signed overflow and saturates in overflow mode
// RULE22: opcodes 0x75, 0x73, 0x70; bit 7 indirect; low 7 bits operand
module dsp_register_load_exec
   import dsp_load_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        INSTR_VALID,
   input  wire logic [15:0] INSTR_WORD,
   input  wire logic [15:0] INSTR_SRC_ADDR,
   input  wire logic [15:0] INDIRECT_ADDR,
   input  wire logic [7:0]  REPEAT_COUNT,
   input  wire logic        SAME_SINGLE_ACCESS_RAM_BLOCK,
   input  wire logic        OPERAND_MODE_BIT,
   output wire logic        INSTR_READY,
   output wire logic        EXEC_BUSY,
   output logic             EXEC_DONE,
   output wire logic        MEM_RD,
   output wire logic [15:0] MEM_ADDR,
   input  wire logic [15:0] MEM_RDATA,
   input  wire logic        MEM_READY,
   output wire logic        PERIPH_WR,
   output wire logic [15:0] PERIPH_ADDR,
   output logic      [15:0] PERIPH_WDATA,
   input  wire logic        PERIPH_READY,
   input  wire logic [6:0]  MAP_RD_ADDR,
   output logic      [15:0] MAP_RD_DATA,
   output logic      [31:0] PRODUCT_REGISTER,
   output logic      [31:0] ACCUMULATOR_REG,
   output logic      [15:0] STATUS_REG_ZERO,
   output logic      [15:0] STATUS_REG_ONE,
   output logic      [15:0] MULT_OPERAND_REG_ZERO,
   output logic      [4:0]  MULT_OPERAND_REG_ONE,
   output logic      [3:0]  MULT_OPERAND_REG_TWO
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic        rst_meta;
   logic        rst_n;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // decode and instruction hold
   // ------------------------------------------------------------
   exec_state_t state;
   exec_state_t next_state;
   instr_kind_t kind;
   instr_kind_t next_kind;
   logic [15:0] ir;
   logic [7:0]  rep_left;
   logic [15:0] data;
   logic        accept;
   logic        exec;
   logic        periph_dst;
   logic        write_done;

   core_link_if link ();

   always_comb begin
      case (INSTR_WORD[15:8])
         OP_PRODUCT_HIGH: next_kind = K_PH; // RULE22
         OP_OPERAND:      next_kind = K_TL; // RULE22
         OP_OPERAND_ACC:  next_kind = K_TLA; // RULE22
         OP_MAPPED_LOAD:  next_kind = K_MAP;
         default: begin
            if (INSTR_WORD[15:9] == OP_STATUS) begin
               next_kind = INSTR_WORD[STATUS_SEL_BIT] ? K_ST1 : K_ST0; // RULE6
            end else begin
               next_kind = K_NONE;
            end
         end
      endcase
   end

   assign accept      = (state == S_IDLE) && INSTR_VALID && (next_kind != K_NONE);
   assign exec        = (state == S_READ) && MEM_READY;
   // operand registers sit inside the peripheral range but are core registers
   assign periph_dst  = (ir[6:0] >= PERIPH_BASE) &&
                        !(ir[6:0] inside {MAP_MULT_OPERAND_REG_ZERO, MAP_MULT_OPERAND_REG_ONE, MAP_MULT_OPERAND_REG_TWO}); // RULE10
   assign write_done  = ((state == S_WRITE) && !periph_dst) ||
                        ((state == S_PORT) && PERIPH_READY);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ir   <= 16'h0000;
         kind <= K_NONE;
      end else if (accept) begin
         ir   <= INSTR_WORD;
         kind <= next_kind;
      end
   end

   // repetitions apply to mapped loads only
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rep_left <= 8'h00;
      end else if (accept) begin
         rep_left <= (next_kind == K_MAP) ? REPEAT_COUNT : 8'h00;
      end else if (write_done && (rep_left != 8'h00)) begin
         rep_left <= rep_left - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (accept) begin
               next_state = SAME_SINGLE_ACCESS_RAM_BLOCK ? S_STALL : S_READ; // RULE13
            end
         end
         S_STALL: next_state = S_READ; // RULE13
         S_READ: begin
            // external wait states simply hold this state
            if (MEM_READY) begin
               next_state = (kind == K_MAP) ? S_WRITE : S_IDLE; // RULE17
            end
         end
         S_WRITE: begin
            if (periph_dst) begin
               next_state = S_PORT; // RULE15
            end else begin
               next_state = (rep_left != 8'h00) ? S_READ : S_IDLE; // RULE14
            end
         end
         S_PORT: begin
            if (PERIPH_READY) begin
               next_state = (rep_left != 8'h00) ? S_READ : S_IDLE; // RULE16
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         EXEC_DONE <= 1'b0;
      end else begin
         EXEC_DONE <= (exec && (kind != K_MAP)) || (write_done && (rep_left == 8'h00));
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         data <= 16'h0000;
      end else if (exec) begin
         data <= MEM_RDATA;
      end
   end

   // ------------------------------------------------------------
   // helpers and memory side
   // ------------------------------------------------------------
   assign link.product_register      = PRODUCT_REGISTER;
   assign link.acc       = ACCUMULATOR_REG;
   assign link.pm        = STATUS_REG_ONE[PM_HI:PM_LO];
   assign link.overflow_mode_bit       = STATUS_REG_ZERO[OVM_BIT];
   assign link.dp        = STATUS_REG_ZERO[8:0];
   assign link.offset    = ir[6:0];
   assign link.indirect  = ir[INDIRECT_BIT];
   assign link.map_src   = (kind == K_MAP);
   assign link.ind_addr  = INDIRECT_ADDR;
   assign link.src_start = INSTR_SRC_ADDR;
   assign link.load      = accept;
   assign link.step      = write_done && (rep_left != 8'h00); // RULE20

   accum_adder u_adder (.lk(link.adder));
   addr_gen    u_addr  (.clk(CLK), .rst_n(rst_n), .lk(link.addr));

   assign INSTR_READY = (state == S_IDLE);
   assign EXEC_BUSY   = (state != S_IDLE);
   assign MEM_RD      = (state == S_READ);
   assign MEM_ADDR    = link.rd_addr;
   assign PERIPH_WR   = (state == S_PORT);
   assign PERIPH_ADDR = link.dst_addr; // RULE19

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         PERIPH_WDATA <= 16'h0000;
      end else if (exec) begin
         PERIPH_WDATA <= MEM_RDATA;
      end
   end

   // ------------------------------------------------------------
   // product and accumulator
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         PRODUCT_REGISTER <= 32'h00000000;
      end else if (exec && (kind == K_PH)) begin
         PRODUCT_REGISTER[31:16] <= MEM_RDATA; // RULE1
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ACCUMULATOR_REG <= 32'h00000000;
      end else if (exec && (kind == K_TLA)) begin
         ACCUMULATOR_REG <= link.sum; // RULE11
      end
   end

   // ------------------------------------------------------------
   // status registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         STATUS_REG_ZERO <= ST0_RESET;
      end else if (exec && (kind == K_ST0)) begin
         // pointer always from the word; any next-pointer field is dropped
         STATUS_REG_ZERO <= MEM_RDATA; // RULE4
         STATUS_REG_ZERO[GLOBAL_INTERRUPT_MASK_BIT] <= STATUS_REG_ZERO[GLOBAL_INTERRUPT_MASK_BIT]; // RULE2
      end else if (exec && (kind == K_ST1)) begin
         STATUS_REG_ZERO[ARP_HI:ARP_LO] <= MEM_RDATA[ARB_HI:ARB_LO]; // RULE5
      end else if (exec && (kind == K_TLA) && link.ovf) begin
         STATUS_REG_ZERO[OV_BIT] <= 1'b1; // RULE21
      end
   end

   // status one only changes on its own load or a load-accumulate
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         STATUS_REG_ONE <= ST1_RESET;
      end else if (exec && (kind == K_ST1)) begin // RULE3
         STATUS_REG_ONE <= MEM_RDATA; // RULE5
      end else if (exec && (kind == K_TLA)) begin
         STATUS_REG_ONE[C_BIT] <= link.carry; // RULE12
      end
   end

   // ------------------------------------------------------------
   // multiplier operand registers
   // ------------------------------------------------------------
   logic        op_load;
   logic        map_wr;

   assign op_load = exec && ((kind == K_TL) || (kind == K_TLA));
   assign map_wr  = (state == S_WRITE) && (kind == K_MAP) && !periph_dst;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         MULT_OPERAND_REG_ZERO <= 16'h0000;
         MULT_OPERAND_REG_ONE  <= 5'h00;
         MULT_OPERAND_REG_TWO  <= 4'h0;
      end else if (op_load) begin
         MULT_OPERAND_REG_ZERO <= MEM_RDATA; // RULE7
         if (!OPERAND_MODE_BIT) begin
            MULT_OPERAND_REG_ONE <= MEM_RDATA[MULT_OPERAND_REG_ONE_W-1:0]; // RULE9
            MULT_OPERAND_REG_TWO <= MEM_RDATA[MULT_OPERAND_REG_TWO_W-1:0]; // RULE9
         end
      end else if (map_wr) begin
         case (ir[6:0])
            MAP_MULT_OPERAND_REG_ZERO: begin
               MULT_OPERAND_REG_ZERO <= data; // RULE10
               if (!OPERAND_MODE_BIT) begin
                  MULT_OPERAND_REG_ONE <= data[MULT_OPERAND_REG_ONE_W-1:0]; // RULE8
                  MULT_OPERAND_REG_TWO <= data[MULT_OPERAND_REG_TWO_W-1:0]; // RULE8
               end
            end
            MAP_MULT_OPERAND_REG_ONE: MULT_OPERAND_REG_ONE <= data[MULT_OPERAND_REG_ONE_W-1:0]; // RULE9
            MAP_MULT_OPERAND_REG_TWO: MULT_OPERAND_REG_TWO <= data[MULT_OPERAND_REG_TWO_W-1:0]; // RULE9
            default: ;
         endcase
      end
   end

   // narrow registers read back zero-extended
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         MAP_RD_DATA <= 16'h0000;
      end else begin
         case (MAP_RD_ADDR)
            MAP_MULT_OPERAND_REG_ZERO: MAP_RD_DATA <= MULT_OPERAND_REG_ZERO; // RULE10
            MAP_MULT_OPERAND_REG_ONE: MAP_RD_DATA <= {11'h000, MULT_OPERAND_REG_ONE};
            MAP_MULT_OPERAND_REG_TWO: MAP_RD_DATA <= {12'h000, MULT_OPERAND_REG_TWO};
            default:   MAP_RD_DATA <= 16'h0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!rst_n);

   high_half_load_a: assert property (exec && kind == K_PH |=> // RULE1
      PRODUCT_REGISTER[31:16] == $past(MEM_RDATA) &&
      PRODUCT_REGISTER[15:0] == $past(PRODUCT_REGISTER[15:0]))
      else $error("product high load wrong");
   global_interrupt_mask_kept_a: assert property (exec && kind == K_ST0 |=> // RULE2
      $stable(STATUS_REG_ZERO[GLOBAL_INTERRUPT_MASK_BIT]))
      else $error("interrupt mask changed");
   buffer_kept_a: assert property (exec && kind == K_ST0 |=> // RULE3
      $stable(STATUS_REG_ONE[ARB_HI:ARB_LO]))
      else $error("pointer buffer changed");
   pointer_word_a: assert property (exec && kind == K_ST0 |=> // RULE4
      STATUS_REG_ZERO[ARP_HI:ARP_LO] == $past(MEM_RDATA[15:13]))
      else $error("pointer not from word");
   st1_copy_a: assert property (exec && kind == K_ST1 |=> // RULE5
      STATUS_REG_ZERO[ARP_HI:ARP_LO] == STATUS_REG_ONE[ARB_HI:ARB_LO])
      else $error("buffer not copied to pointer");
   compat_load_a: assert property (op_load && !OPERAND_MODE_BIT |=> // RULE8
      MULT_OPERAND_REG_ONE == $past(MEM_RDATA[4:0]) &&
      MULT_OPERAND_REG_TWO == $past(MEM_RDATA[3:0]))
      else $error("operand copies missing");
   carry_out_a: assert property (exec && kind == K_TLA |=> // RULE12
      STATUS_REG_ONE[C_BIT] == $past(link.carry))
      else $error("carry not updated");
   one_cycle_a: assert property (exec && kind != K_MAP |=> // RULE13
      state == S_IDLE && EXEC_DONE)
      else $error("load took extra cycle");
   stall_once_a: assert property (state == S_STALL |=> state == S_READ) // RULE13
      else $error("stall too long");
   port_step_a: assert property (state == S_WRITE && periph_dst |=> // RULE16
      PERIPH_WR ##0 PERIPH_ADDR[15:7] == PAGE_ZERO)
      else $error("port write missing");
   src_next_a: assert property (link.step |=> // RULE20
      state == S_READ && MEM_ADDR == $past(MEM_ADDR) + 16'h0001)
      else $error("source not incremented");

   cover_compat_c: cover property (op_load && !OPERAND_MODE_BIT);
   cover_repeat_c: cover property (link.step ##2 link.step);
   cover_port_c:   cover property (PERIPH_WR && PERIPH_READY);
   cover_sat_c:    cover property (exec && kind == K_TLA && link.ovf && link.overflow_mode_bit);

endmodule

// File: mem_partner.sv
// data memory and port on the far side; wait states set by the bench
module mem_partner (
   input  wire logic        clk,
   input  wire logic        rd,
   input  wire logic [15:0] addr,
   input  wire logic [1:0]  rd_waits,
   input  wire logic        wr,
   input  wire logic [1:0]  io_waits,
   output logic      [15:0] rdata,
   output logic             ready,
   output logic             wr_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:255];
   logic [15:0] last = 16'h0000;
   logic [1:0]  rcnt = 2'h0;
   logic [1:0]  wcnt = 2'h0;

   always_ff @(posedge clk) begin
      rcnt <= (rd && !ready) ? rcnt + 2'h1 : 2'h0;
      wcnt <= (wr && !wr_ready) ? wcnt + 2'h1 : 2'h0;
      if (ready)
         last <= rdata;
   end

   // released bus shows the inverse of the last word, never a stale copy
   always_comb begin
      ready    = rd && (rcnt == rd_waits);
      wr_ready = wr && (wcnt == io_waits);
      rdata    = ready ? mem[addr[7:0]] : ~last;
   end
endmodule

// File: tb_dsp_register_load_exec.sv
module tb_dsp_register_load_exec
   import dsp_load_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] op; logic [15:0] d; logic operand_mode_bit; logic sr;} row_t;
   logic        CLK, RESET_N, INSTR_VALID, SAME_SINGLE_ACCESS_RAM_BLOCK, OPERAND_MODE_BIT, INSTR_READY;
   logic        EXEC_BUSY, EXEC_DONE, MEM_RD, MEM_READY, PERIPH_WR, PERIPH_READY;
   logic [15:0] INSTR_WORD, INSTR_SRC_ADDR, INDIRECT_ADDR, MEM_ADDR, MEM_RDATA, PERIPH_ADDR;
   logic [15:0] PERIPH_WDATA, MAP_RD_DATA, STATUS_REG_ZERO, STATUS_REG_ONE;
   logic [15:0] MULT_OPERAND_REG_ZERO, s0, s1, t0, last_addr, pa;
   logic [31:0] PRODUCT_REGISTER, ACCUMULATOR_REG, product_register;
   logic [7:0]  REPEAT_COUNT;
   logic [6:0]  MAP_RD_ADDR, off;
   logic [4:0]  MULT_OPERAND_REG_ONE, t1;
   logic [3:0]  MULT_OPERAND_REG_TWO, t2;
   logic [1:0]  rd_waits, io_waits;
   logic [15:0] wq[$];
   int          n_errors, tests_run, cyc;
   row_t        rows [6] = '{{8'h73, 16'h00b7, 1'b0, 1'b0}, {8'h73, 16'h0062, 1'b1, 1'b1},
                             {8'h75, 16'hf79c, 1'b1, 1'b0}, {8'h0e, 16'he002, 1'b1, 1'b1},
                             {8'h0f, 16'ha1bc, 1'b1, 1'b0}, {8'h75, 16'h0001, 1'b0, 1'b1}};

   dsp_register_load_exec DUT (.CLK, .RESET_N, .INSTR_VALID, .INSTR_WORD, .INSTR_SRC_ADDR,
      .INDIRECT_ADDR, .REPEAT_COUNT, .SAME_SINGLE_ACCESS_RAM_BLOCK, .OPERAND_MODE_BIT, .INSTR_READY,
      .EXEC_BUSY, .EXEC_DONE, .MEM_RD, .MEM_ADDR, .MEM_RDATA, .MEM_READY, .PERIPH_WR,
      .PERIPH_ADDR, .PERIPH_WDATA, .PERIPH_READY, .MAP_RD_ADDR, .MAP_RD_DATA,
      .PRODUCT_REGISTER, .ACCUMULATOR_REG, .STATUS_REG_ZERO, .STATUS_REG_ONE,
      .MULT_OPERAND_REG_ZERO, .MULT_OPERAND_REG_ONE, .MULT_OPERAND_REG_TWO);
   mem_partner p (.clk(CLK), .rd(MEM_RD), .addr(MEM_ADDR), .rd_waits(rd_waits),
      .wr(PERIPH_WR), .io_waits(io_waits), .rdata(MEM_RDATA), .ready(MEM_READY),
      .wr_ready(PERIPH_READY));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // offered on one edge, taken on the next; counts edges until the done pulse
   task automatic run(input logic [15:0] w, input logic [15:0] src, input logic [7:0] rep,
                      input logic sr, input logic operand_mode_bit);
      @(posedge CLK);
      INSTR_WORD <= w;
      INSTR_SRC_ADDR <= src;
      REPEAT_COUNT <= rep;
      SAME_SINGLE_ACCESS_RAM_BLOCK <= sr;
      OPERAND_MODE_BIT <= operand_mode_bit;
      INSTR_VALID <= 1'b1;
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      cyc = 0;
      do begin
         @(posedge CLK);
         #1;
         cyc++;
      end while (EXEC_DONE !== 1'b1 && cyc < 60);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge CLK) begin
      if (MEM_RD && MEM_READY)
         last_addr <= MEM_ADDR;
      if (PERIPH_WR && PERIPH_READY) begin
         wq.push_back(PERIPH_WDATA);
         pa <= PERIPH_ADDR;
      end
   end

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   initial begin
      #20000;
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {RESET_N, INSTR_VALID, SAME_SINGLE_ACCESS_RAM_BLOCK, OPERAND_MODE_BIT} = 4'h1;
      {INSTR_WORD, INSTR_SRC_ADDR, INDIRECT_ADDR, REPEAT_COUNT} = 56'h0;
      {MAP_RD_ADDR, rd_waits, io_waits} = 11'h0;
      RESET_N = 1'b0;
      for (int i = 0; i < 256; i++)
         p.mem[i] = 16'(i) ^ 16'h5a00;
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (3) @(posedge CLK);
      #1;
      {product_register, s0, s1, t0, t1, t2} = {32'h0, ST0_RESET, ST1_RESET, 25'h0};
      chk(STATUS_REG_ZERO, s0, "st0 reset");
      chk(STATUS_REG_ONE, s1, "st1 reset");
      chk({INSTR_READY, EXEC_BUSY, MEM_RD, PERIPH_WR}, 32'h8, "idle outputs");
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         off = 7'h10 + 7'(i);
         p.mem[{1'b0, off}] = rows[i].d;
         run({rows[i].op, 1'b0, off}, 16'h0, 8'h0, rows[i].sr, rows[i].operand_mode_bit);
         case (rows[i].op)
            8'h75: product_register = {rows[i].d, product_register[15:0]};
            8'h73: begin
               t0 = rows[i].d;
               if (!rows[i].operand_mode_bit)
                  {t1, t2} = {rows[i].d[4:0], rows[i].d[3:0]};
            end
            8'h0e: s0 = {rows[i].d[15:10], s0[9], rows[i].d[8:0]};
            default: {s1, s0[15:13]} = {rows[i].d, rows[i].d[15:13]};
         endcase
         chk(32'(cyc), 32'(1 + rows[i].sr), "cycles");
         chk(PRODUCT_REGISTER, product_register, "product");
         chk(STATUS_REG_ZERO, s0, "st0");
         chk(STATUS_REG_ONE, s1, "st1");
         chk({MULT_OPERAND_REG_ZERO, 7'h0, MULT_OPERAND_REG_ONE, MULT_OPERAND_REG_TWO},
             {t0, 7'h0, t1, t2}, "operands");
         $display("test row %0d done", i);
      end
      p.mem[8'h20] = 16'h0001;
      run(16'h0e20, 16'h0, 8'h0, 1'b0, 1'b1);
      chk(STATUS_REG_ZERO, 16'h0001 | (s0 & 16'h0200), "page");
      run(16'h7305, 16'h0, 8'h0, 1'b0, 1'b1);
      chk(last_addr, 16'h0085, "direct addr");
      run(16'h8924, 16'h0050, 8'h0, 1'b0, 1'b0);
      chk(32'(cyc), 32'd2, "mapped core");
      chk(MULT_OPERAND_REG_ONE, p.mem[8'h50][4:0], "mapped op");
      io_waits = 2'h1;
      wq.delete();
      run(16'h8930, 16'h0060, 8'h2, 1'b0, 1'b1);
      chk(32'(cyc), 32'd12, "port rpt");
      chk(32'(wq.size()), 32'd3, "port writes");
      for (int k = 0; k < 3; k++)
         chk(wq[k], p.mem[8'h60 + k], "src step");
      chk(pa, 16'h0030, "page zero");
      io_waits = 2'h0;
      run(16'h8931, 16'h0064, 8'h0, 1'b0, 1'b1);
      chk(32'(cyc), 32'd3, "port single");
      rd_waits = 2'h2;
      run(16'h8925, 16'h0070, 8'h1, 1'b0, 1'b1);
      chk(32'(cyc), 32'd8, "ext rpt");
      rd_waits = 2'h0;
      MAP_RD_ADDR <= 7'h25;
      @(posedge CLK);
      #1;
      chk(MAP_RD_DATA, {11'h0, p.mem[8'h71][4:0]}, "map read");
      $display("test mapped done");
      INDIRECT_ADDR <= 16'h0040;
      p.mem[8'h40] = 16'ha800;
      run(16'h0e8b, 16'h0, 8'h0, 1'b0, 1'b1);
      chk(STATUS_REG_ZERO, 16'haa00, "indirect st0");
      {p.mem[8'h30], p.mem[8'h31], p.mem[8'h32]} = 48'h4000_1234_c000;
      run(16'h7530, 16'h0, 8'h0, 1'b0, 1'b1);
      run(16'h7031, 16'h0, 8'h0, 1'b0, 1'b1);
      chk(ACCUMULATOR_REG, 32'h40000000, "acc add");
      chk(MULT_OPERAND_REG_ZERO, 16'h1234, "acc op");
      run(16'h7031, 16'h0, 8'h0, 1'b0, 1'b1);
      chk(ACCUMULATOR_REG, 32'h7fffffff, "saturate");
      chk({STATUS_REG_ZERO[12], STATUS_REG_ONE[9]}, 32'h2, "ov set");
      run(16'h7532, 16'h0, 8'h0, 1'b0, 1'b1);
      run(16'h7031, 16'h0, 8'h0, 1'b0, 1'b1);
      chk(ACCUMULATOR_REG, 32'h3fffffff, "carry sum");
      chk(STATUS_REG_ONE[9], 32'h1, "carry");
      $display("test accumulate done");
      print_verdict();
   end
endmodule
